//--- core/gtc_pkg.sv
// package for the gated 16-bit timer counter
package gtc_pkg;
    // register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_GATE = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_STAT = 3'h4;
    // timer_control_reg fields
    localparam int CTRL_ON = 0;
    localparam int CTRL_SYNC_DIS = 2;
    localparam int CTRL_OSC_EN = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_EXT_SEL = 6;
    // gate_control_reg fields
    localparam int GATE_SS_LO = 0;
    localparam int GATE_POL = 6;
    localparam int GATE_EN = 7;
    // status fields
    localparam int STAT_OVF = 0;
    localparam int STAT_OSC_RUN = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] GATE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [2:0] PS_RST = 3'h0;
    localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
    localparam logic [1:0] GSS_PIN = 2'h0;
    localparam logic [1:0] GSS_T8OVF = 2'h1;
    localparam logic [1:0] GSS_RSV2 = 2'h2;
    localparam logic [1:0] GSS_RSV3 = 2'h3;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gtc_bus_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] gate;
        logic [15:0] cnt;
        logic [2:0] ps;
        logic ovf;
        logic [7:0] rdata;
        logic osc_en;
        logic [2:0] clk_sync;
        logic [1:0] gate_sync;
        logic [1:0] t8_sync;
        logic t8_prev;
        logic t8_evt;
    } gtc_state_s;
endpackage

//--- core/gtc_timer.sv
// gated 16-bit timer counter with prescaler, gate and register port
// Notes on behaviour
// [RL1] the counter clock is divided by 1, 2, 4 or 8 per prescale_select.
// [RL2] the prescaler is hidden from software; a count byte write clears it.
// [RL3] the crystal oscillator runs only while enabled, and on in sleep.
// [RL4] software enables the oscillator and waits before counting from it.
// [RL5] with sync_disable set, pin edges reach the counter unsynchronised; the code synchronises them in both modes.
// [RL6] async external counting runs in sleep; overflow can wake the core.
// [RL7] switching sync mode may lose or add one increment.
// [RL8] a count byte read while counting externally returns a stable value.
// [RL9] software must allow for overflow between reading the two count bytes.
// [RL10] software should stop the counter before writing the count.
// [RL11] gate_enable turns gating on; gate_polarity sets the active level.
// [RL12] with gating on, clock edges count while gate equals polarity.
// [RL13] with gating on and gate unequal to polarity the count holds.
// [RL14] gate_source_select 00 is the gate pin, 01 the 8-bit timer overflow.
// [RL15] the count wraps from all ones to zero and sets the overflow flag.
// [RL16] gate sources 10 and 11 are reserved and read as inactive; the code reads them as level 0, which is active when gate_polarity is 0.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire gtc_pkg::gtc_bus_s bus_i,
    input wire logic counter_clock_i,
    input wire logic gate_input_level_i,
    input wire logic eight_bit_timer_ovf_i,
    input wire logic sleep_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic crystal_osc_enable_o
);
    import gtc_pkg::*;

    gtc_state_s s_r;
    gtc_state_s s_nxt;
    logic tick;
    logic gate_lvl;
    logic gate_ok;
    logic ps_done;
    logic [2:0] ps_inc;

    // terminal value of the prescaler for a given select code
    function automatic logic [2:0] ps_limit(input logic [1:0] sel);
        ps_limit = 3'((4'h1 << sel) - 4'h1);
    endfunction

    always_comb
    begin
        s_nxt = s_r;
        // two-flop sync of asynchronous inputs; stage 2 feeds edge logic
        s_nxt.clk_sync = {s_r.clk_sync[1:0], counter_clock_i};
        s_nxt.gate_sync = {s_r.gate_sync[0], gate_input_level_i};
        s_nxt.t8_sync = {s_r.t8_sync[0], eight_bit_timer_ovf_i};
        s_nxt.t8_prev = s_r.t8_sync[1];
        // overflow of the 8-bit timer as a gate event
        s_nxt.t8_evt = s_r.t8_sync[1] & ~s_r.t8_prev; // RL14
        // clock source: external pin edge or system clock; the same
        // synchronised edge serves both sync modes, so mode changes
        // move at most one increment
        if (s_r.ctrl[CTRL_EXT_SEL])
        begin
            tick = s_r.clk_sync[1] & ~s_r.clk_sync[2]; // RL5 RL7
        end
        else
        begin
            tick = ~sleep_i;
        end
        // sleep stops all counting except asynchronous external
        if (sleep_i && !(s_r.ctrl[CTRL_SYNC_DIS] && s_r.ctrl[CTRL_EXT_SEL]))
        begin
            tick = 1'b0; // RL6
        end
        if (s_r.gate[GATE_SS_LO +: 2] == GSS_PIN)
        begin
            gate_lvl = s_r.gate_sync[1]; // RL14
        end
        else if (s_r.gate[GATE_SS_LO +: 2] == GSS_T8OVF)
        begin
            gate_lvl = s_r.t8_evt; // RL14
        end
        else
        begin
            gate_lvl = 1'b0; // RL16
        end
        gate_ok = !s_r.gate[GATE_EN]
            || (gate_lvl == s_r.gate[GATE_POL]); // RL11 RL12 RL13
        ps_done = (s_r.ps == ps_limit(s_r.ctrl[CTRL_PS_LO +: 2])); // RL1
        ps_inc = 3'(s_r.ps + 3'h1);
        if (s_r.ctrl[CTRL_ON] && tick && gate_ok)
        begin
            if (ps_done)
            begin
                s_nxt.ps = PS_RST; // RL1
                s_nxt.cnt = 16'(s_r.cnt + 16'h0001); // RL15
                if (s_r.cnt == CNT_ALL_ONES)
                begin
                    s_nxt.ovf = 1'b1; // RL15
                end
            end
            else
            begin
                s_nxt.ps = ps_inc; // RL1
            end
        end
        // oscillator stays on in sleep while its enable is set
        s_nxt.osc_en = s_r.ctrl[CTRL_OSC_EN]; // RL3
        // read data valid the cycle after the strobe only
        s_nxt.rdata = 8'h00;
        if (bus_i.rd)
        begin
            if (bus_i.addr == ADDR_CTRL)
            begin
                s_nxt.rdata = s_r.ctrl;
            end
            else if (bus_i.addr == ADDR_GATE)
            begin
                s_nxt.rdata = s_r.gate;
            end
            else if (bus_i.addr == ADDR_CNT_LO)
            begin
                s_nxt.rdata = s_r.cnt[7:0]; // RL8
            end
            else if (bus_i.addr == ADDR_CNT_HI)
            begin
                s_nxt.rdata = s_r.cnt[15:8]; // RL8
            end
            else if (bus_i.addr == ADDR_STAT)
            begin
                s_nxt.rdata[STAT_OVF] = s_r.ovf;
                s_nxt.rdata[STAT_OSC_RUN] = s_r.osc_en;
            end
        end
        if (bus_i.wr)
        begin
            if (bus_i.addr == ADDR_CTRL)
            begin
                s_nxt.ctrl = bus_i.wdata;
                s_nxt.ps = PS_RST; // RL1
            end
            else if (bus_i.addr == ADDR_GATE)
            begin
                s_nxt.gate = bus_i.wdata;
            end
            else if (bus_i.addr == ADDR_CNT_LO)
            begin
                s_nxt.cnt[7:0] = bus_i.wdata;
                s_nxt.ps = PS_RST; // RL2
            end
            else if (bus_i.addr == ADDR_CNT_HI)
            begin
                s_nxt.cnt[15:8] = bus_i.wdata;
                s_nxt.ps = PS_RST; // RL2
            end
            else if (bus_i.addr == ADDR_STAT)
            begin
                // write one clears; a wrap in the same cycle wins only while the flag is still clear
                if (bus_i.wdata[STAT_OVF] && !(s_nxt.ovf && !s_r.ovf))
                begin
                    s_nxt.ovf = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign irq_o = s_r.ovf;
    assign crystal_osc_enable_o = s_r.osc_en;

    property p_wrap_flag;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.cnt == CNT_ALL_ONES && s_nxt.cnt == CNT_RST && !bus_i.wr)
        |=> s_r.ovf;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap"); // RL15

    property p_gate_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.gate[GATE_EN] && gate_lvl != s_r.gate[GATE_POL] && !bus_i.wr)
        |=> $stable(s_r.cnt);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate"); // RL13

    property p_ps_clear;
        @(posedge clk_i) disable iff (!rstn_i)
        (bus_i.wr && (bus_i.addr == ADDR_CNT_LO || bus_i.addr == ADDR_CNT_HI))
        |=> s_r.ps == PS_RST;
    endproperty
    a_ps_clear: assert property (p_ps_clear) else $error("ps kept"); // RL2

    property p_ps_bound;
        @(posedge clk_i) disable iff (!rstn_i)
        1'b1 |-> s_r.ps <= ps_limit(s_r.ctrl[CTRL_PS_LO +: 2])
            || $changed(s_r.ctrl);
    endproperty
    a_ps_bound: assert property (p_ps_bound) else $error("ps range"); // RL1

    property p_osc;
        @(posedge clk_i) disable iff (!rstn_i)
        1'b1 |=> crystal_osc_enable_o == $past(s_r.ctrl[CTRL_OSC_EN]);
    endproperty
    a_osc: assert property (p_osc) else $error("osc enable"); // RL3

    property p_sleep_stop;
        @(posedge clk_i) disable iff (!rstn_i)
        (sleep_i && !s_r.ctrl[CTRL_EXT_SEL] && !bus_i.wr)
        |=> $stable(s_r.cnt);
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("sleep"); // RL6

    property p_rsv_gate;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_r.gate[GATE_SS_LO +: 2] == GSS_RSV2
            || s_r.gate[GATE_SS_LO +: 2] == GSS_RSV3)
        |-> !gate_lvl;
    endproperty
    a_rsv_gate: assert property (p_rsv_gate) else $error("rsv gate"); // RL16

    property p_cnt_read;
        @(posedge clk_i) disable iff (!rstn_i)
        (bus_i.rd && bus_i.addr == ADDR_CNT_LO)
        |=> rdata_o == $past(s_r.cnt[7:0]);
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("read lo"); // RL8

    // pin edge counted while asleep in asynchronous mode
    sequence s_asy_tick;
        sleep_i && s_r.ctrl[CTRL_ON] && s_r.ctrl[CTRL_EXT_SEL]
            && s_r.ctrl[CTRL_SYNC_DIS] && !s_r.gate[GATE_EN]
            && s_r.clk_sync[1] && !s_r.clk_sync[2]
            && ps_done && !bus_i.wr;
    endsequence

    property p_asy_run;
        @(posedge clk_i) disable iff (!rstn_i)
        s_asy_tick
        |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h0001);
    endproperty
    a_asy_run: assert property (p_asy_run) else $error("asy run"); // RL5 RL6

    // gate level matching polarity lets a due tick through
    sequence s_gate_pass;
        s_r.ctrl[CTRL_ON] && s_r.gate[GATE_EN] && tick && ps_done
            && gate_lvl == s_r.gate[GATE_POL] && !bus_i.wr;
    endsequence

    property p_gate_run;
        @(posedge clk_i) disable iff (!rstn_i)
        s_gate_pass
        |=> s_r.cnt == 16'($past(s_r.cnt) + 16'h0001);
    endproperty
    a_gate_run: assert property (p_gate_run) else $error("gate run"); // RL12

    // prescaler steps without touching the count
    sequence s_ps_step;
        s_r.ctrl[CTRL_ON] && tick && gate_ok && !ps_done && !bus_i.wr;
    endsequence

    property p_ps_step;
        @(posedge clk_i) disable iff (!rstn_i)
        s_ps_step
        |=> s_r.ps == 3'($past(s_r.ps) + 3'h1) && $stable(s_r.cnt);
    endproperty
    a_ps_step: assert property (p_ps_step) else $error("ps step"); // RL1

    // write one to status clears the flag when no wrap is due
    sequence s_ovf_clr;
        bus_i.wr && bus_i.addr == ADDR_STAT && bus_i.wdata[STAT_OVF]
            && !(s_r.cnt == CNT_ALL_ONES && s_nxt.cnt == CNT_RST);
    endsequence

    property p_ovf_clr;
        @(posedge clk_i) disable iff (!rstn_i)
        s_ovf_clr
        |=> !s_r.ovf;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("ovf clr"); // RL15

    property p_ovf_keep;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.ovf && !(bus_i.wr && bus_i.addr == ADDR_STAT)
        |=> s_r.ovf;
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("ovf keep"); // RL15

    property p_rd_hi;
        @(posedge clk_i) disable iff (!rstn_i)
        (bus_i.rd && bus_i.addr == ADDR_CNT_HI)
        |=> rdata_o == $past(s_r.cnt[15:8]);
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read hi"); // RL8

    property p_rd_idle;
        @(posedge clk_i) disable iff (!rstn_i)
        !bus_i.rd
        |=> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read idle");

    property p_ctrl_wr;
        @(posedge clk_i) disable iff (!rstn_i)
        (bus_i.wr && bus_i.addr == ADDR_CTRL)
        |=> s_r.ctrl == $past(bus_i.wdata) && s_r.ps == PS_RST;
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl wr"); // RL1

    property p_gate_wr;
        @(posedge clk_i) disable iff (!rstn_i)
        (bus_i.wr && bus_i.addr == ADDR_GATE)
        |=> s_r.gate == $past(bus_i.wdata);
    endproperty
    a_gate_wr: assert property (p_gate_wr) else $error("gate wr"); // RL11

    property p_osc_sleep;
        @(posedge clk_i) disable iff (!rstn_i)
        (sleep_i && s_r.ctrl[CTRL_OSC_EN])
        |=> crystal_osc_enable_o;
    endproperty
    a_osc_sleep: assert property (p_osc_sleep) else $error("osc"); // RL3

    property p_t8_pulse;
        @(posedge clk_i) disable iff (!rstn_i)
        s_r.t8_evt
        |=> !s_r.t8_evt;
    endproperty
    a_t8_pulse: assert property (p_t8_pulse) else $error("t8 pulse"); // RL14

    property p_off_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        (!s_r.ctrl[CTRL_ON] && !bus_i.wr)
        |=> $stable(s_r.cnt);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("off hold");
endmodule
`default_nettype wire

//--- tb/gtc_partner.sv
// far-side model: external counter clock pin and 8-bit timer overflow
`timescale 1ns/1ps
`default_nettype none
module gtc_partner (
    input wire logic clk_i,
    input wire logic run_i,
    output logic counter_clock_o,
    output logic t8_ovf_o
);
    logic [7:0] t8_r;
    logic [1:0] div_r;
    initial {t8_r, div_r, counter_clock_o, t8_ovf_o} = '0;
    // 8-bit timer steps each cycle; pin clock toggles every 4 cycles
    always @(posedge clk_i)
    begin
        t8_r <= t8_r + 8'h01;
        t8_ovf_o <= (t8_r == 8'hFF);
        div_r <= div_r + 2'h1;
        if (run_i && div_r == 2'h3)
            counter_clock_o <= ~counter_clock_o;
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the gated 16-bit timer counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gtc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    gtc_bus_s bus_i = '0;
    logic pin_clk, gate_pin = 1'b0, t8_ovf, sleep = 1'b0, run = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o, osc_en;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] v0, v1;
    gtc_timer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
        .counter_clock_i(pin_clk), .gate_input_level_i(gate_pin),
        .eight_bit_timer_ovf_i(t8_ovf), .sleep_i(sleep),
        .rdata_o(rdata_o), .irq_o(irq_o), .crystal_osc_enable_o(osc_en));
    gtc_partner far (.clk_i(clk_i), .run_i(run), .counter_clock_o(pin_clk),
        .t8_ovf_o(t8_ovf));
    initial forever #2 clk_i = ~clk_i;
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= gtc_bus_s'{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus_i <= '0;
    endtask
    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus_i <= gtc_bus_s'{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 d = rdata_o;
    endtask
    // count gained over exactly n cycles, read from the low byte
    task rate(input int n, input logic [7:0] e);
        rd(ADDR_CNT_LO, v0);
        repeat (n - 2) @(posedge clk_i);
        rd(ADDR_CNT_LO, v1);
        chk(v1 - v0, e);
    endtask
    task t_reset;
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), v0);
            chk(v0, 8'h00);
        end
        chk({7'h00, irq_o}, 8'h00);
    endtask
    task t_prescale;
        for (int p = 0; p < 4; p++)
        begin
            wr(ADDR_CTRL, 8'h01 | 8'(p << 4));
            rate(64, 8'(64 >> p));
        end
    endtask
    task t_clear;
        logic [7:0] r[2];
        wr(ADDR_CTRL, 8'h31);
        for (int k = 0; k < 2; k++)
        begin
            repeat (k * 3 + 1) @(posedge clk_i);
            wr(ADDR_CNT_LO, 8'h00);
            repeat (20) @(posedge clk_i);
            rd(ADDR_CNT_LO, r[k]);
        end
        chk(r[1], r[0]);
        chk(r[0], 8'h02);
    endtask
    task t_ovf;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_HI, 8'hFF);
        wr(ADDR_CNT_LO, 8'hFF);
        chk({7'h00, irq_o}, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        rd(ADDR_CNT_HI, v0);
        chk(v0, 8'h00);
        rd(ADDR_CNT_LO, v1);
        chk(v1, 8'h01);
        wr(ADDR_STAT, 8'h01);
        rd(ADDR_STAT, v0);
        chk(v0, 8'h00);
    endtask
    task t_gate;
        for (int i = 0; i < 4; i++)
        begin
            gate_pin <= i[0];
            wr(ADDR_GATE, 8'h80 | (8'(i[1]) << 6));
            wr(ADDR_CTRL, 8'h01);
            repeat (6) @(posedge clk_i);
            rate(32, (i[0] == i[1]) ? 8'h20 : 8'h00);
        end
        wr(ADDR_GATE, 8'hC1);
        rate(512, 8'd2);
        for (int s = 2; s < 4; s++)
        begin
            wr(ADDR_GATE, 8'hC0 | 8'(s));
            rate(64, 8'd0);
        end
        wr(ADDR_GATE, 8'h40);
        rate(32, 8'd32);
    endtask
    task t_ext;
        run <= 1'b1;
        sleep <= 1'b1;
        // oscillator first, then a settling wait before counting from it
        wr(ADDR_CTRL, 8'h08);
        repeat (16) @(posedge clk_i);
        wr(ADDR_CTRL, 8'h4D);
        repeat (8) @(posedge clk_i);
        rate(64, 8'h08);
        wr(ADDR_CTRL, 8'h49);
        repeat (8) @(posedge clk_i);
        rate(64, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        rate(64, 8'h00);
        wr(ADDR_CTRL, 8'h08);
        rd(ADDR_STAT, v0);
        chk({7'h00, osc_en}, 8'h01);
        chk(v0 & 8'h02, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_STAT, v0);
        chk({7'h00, osc_en}, 8'h00);
        sleep <= 1'b0;
    endtask
    task conclude;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #80000;
        num_errors++;
        conclude;
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_reset;
        t_prescale;
        t_clear;
        t_ovf;
        t_gate;
        t_ext;
        conclude;
    end
endmodule
`default_nettype wire
